// file: epa_pkg.sv
// Constants, register map and carrier types for the energy pulse block.
// Assumes a 125 MHz ref_clk and an APB master with 32-bit data.
// Function
// - Converter pulse per readable energy LSB step
// - One output pulse per (den+1)/(num+1) pulses
// - Numerator and denominator are unsigned 12-bit
// - Zero in numerator or denominator acts one
// - Clamp scale ratio to at most one
// - Effective num and den both one: width 16 quarter-clock periods
// - Periods beyond 180 ms: fixed 90 ms width
// - Otherwise calibration output has half duty
// - Mode bit 7 enables line-cycle accumulation
// - Line-cycle runs start and stop on crossings
// - Line-cycle energy lands at offset 0x04
// - Half-cycle count from 16-bit register 0x1C
// - Completion sets status bit 2, interrupt
// - Line-cycle runs repeat while mode bit set
// - Positive-only mode drops negative power
// - Mode bit 15 enables positive-only, off default
// - Direction change sets to-positive or to-negative
// - No accumulation below no-load threshold
// - Signed add every four clocks, 49 bits
package epa_pkg;
	// -----------------------------------------------------------
	// Register map (byte addresses)
	// -----------------------------------------------------------
	localparam logic [7:0] EPA_LC_ENERGY_OFS = 8'h04;
	localparam logic [7:0] EPA_HALF_CYC_OFS = 8'h1C;
	localparam logic [7:0] EPA_MODE_OFS = 8'h24;
	localparam logic [7:0] EPA_NUM_OFS = 8'h28;
	localparam logic [7:0] EPA_DEN_OFS = 8'h2C;
	localparam logic [7:0] EPA_IRQ_EN_OFS = 8'h30;
	localparam logic [7:0] EPA_STATUS_OFS = 8'h34;
	localparam logic [7:0] EPA_ENERGY_OFS = 8'h38;

	// -----------------------------------------------------------
	// Field positions and reset values
	// -----------------------------------------------------------
	localparam int EPA_MODE_CYC_BIT = 7;
	localparam int EPA_MODE_POS_BIT = 15;
	localparam int EPA_ST_CYC_END_BIT = 2;
	localparam int EPA_ST_TO_POS_BIT = 4;
	localparam int EPA_ST_TO_NEG_BIT = 5;
	localparam logic [15:0] EPA_MODE_RST = 16'h0000;
	localparam logic [11:0] EPA_RATIO_RST = 12'h000;
	localparam logic [15:0] EPA_HALF_CYC_RST = 16'hFFFF;
	localparam logic [7:0] EPA_IRQ_EN_RST = 8'h00;
	localparam logic [7:0] EPA_STATUS_MASK = 8'h34;

	// -----------------------------------------------------------
	// Datapath sizes and timing
	// -----------------------------------------------------------
	localparam int EPA_ACC_W = 49;
	localparam int EPA_RD_LSB = 25;
	localparam int EPA_TICK_DIV = 4;
	localparam logic [23:0] EPA_NOLOAD_THRESH = 24'h000009;
	localparam int EPA_CLK_KHZ = 125000;
	localparam int EPA_FIXED_QCLK = 16;
	localparam int EPA_FIXED_CLKS = EPA_FIXED_QCLK * EPA_TICK_DIV;
	localparam int EPA_LONG_MS = 180;
	localparam int EPA_WIDE_MS = 90;
	localparam int EPA_LONG_CLKS = EPA_LONG_MS * EPA_CLK_KHZ;
	localparam int EPA_WIDE_CLKS = EPA_WIDE_MS * EPA_CLK_KHZ;

	// Line-cycle sequencer states
	typedef enum logic [2:0] {
		EPA_LC_IDLE = 3'b001,
		EPA_LC_WAIT = 3'b010,
		EPA_LC_RUN = 3'b100
	} epa_lc_state_t;

	// APB request carrier
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} epa_apb_req_t;

	// APB answer carrier
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} epa_apb_rsp_t;
endpackage : epa_pkg

// file: epa_energy_pulse.sv
// Energy accumulator, calibration pulse generator and line-cycle sequencer.
// Assumes active_power is a signed sample held stable by the datapath and
// zero_cross is a one-cycle pulse per voltage zero crossing, both synchronous.
`timescale 1ns/1ns
`default_nettype none
module epa_energy_pulse #(
	parameter logic [24:0] LONG_CLKS = 25'(epa_pkg::EPA_LONG_CLKS),
	parameter logic [24:0] WIDE_CLKS = 25'(epa_pkg::EPA_WIDE_CLKS)
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire epa_pkg::epa_apb_req_t apb_req,
	output epa_pkg::epa_apb_rsp_t apb_rsp,
	input wire logic signed [23:0] active_power,
	input wire logic zero_cross,
	output logic calibration_pulse_out,
	output logic irq_n_o,
	output logic irq_n_oe
);
	// -----------------------------------------------------------
	// State
	// -----------------------------------------------------------
	typedef struct packed {
		epa_pkg::epa_apb_rsp_t rsp;
		logic [15:0] mode;
		logic [11:0] num;
		logic [11:0] den;
		logic [15:0] half_cyc;
		logic [7:0] irq_en;
		logic [7:0] status;
		logic [1:0] tick;
		logic [48:0] acc;
		logic [48:0] lc_acc;
		logic [23:0] lc_energy;
		epa_pkg::epa_lc_state_t lc_state;
		logic [15:0] lc_cnt;
		logic dir_known;
		logic dir_pos;
		logic [12:0] frac;
		logic [24:0] period_cnt;
		logic [24:0] period;
		logic [24:0] width_cnt;
		logic cf;
		logic irq;
	} epa_state_t;

	epa_state_t st_q;
	epa_state_t st_d;

	logic step;
	logic neg;
	logic [24:0] mag;
	logic above;
	logic contrib;
	logic [48:0] acc_sum;
	logic dfc;
	logic [11:0] num_nz;
	logic [11:0] den_nz;
	logic [11:0] eff_num;
	logic [11:0] eff_den;
	logic [13:0] frac_sum;
	logic cf_evt;
	logic fixed_width;
	logic [24:0] width;
	logic [15:0] cyc_target;
	logic lc_done;
	logic to_pos;
	logic to_neg;
	logic wr;
	logic setup;
	logic [31:0] rdata;
	logic hit;
	logic [7:0] st_set;

	// -----------------------------------------------------------
	// Energy datapath
	// -----------------------------------------------------------
	// Accumulator steps on one clock of every four
	always_comb begin
		step = (st_q.tick == 2'(epa_pkg::EPA_TICK_DIV - 1));
		neg = active_power[23];
		mag = neg ? (25'd0 - {active_power[23], active_power}) : {1'b0, active_power};
		above = (mag >= {1'b0, epa_pkg::EPA_NOLOAD_THRESH});
		contrib = step && above && !(st_q.mode[epa_pkg::EPA_MODE_POS_BIT] && neg);
		acc_sum = st_q.acc + {{25{active_power[23]}}, active_power};
		// One readable LSB per step at most, so a bit flip marks a pulse
		dfc = contrib && (acc_sum[epa_pkg::EPA_RD_LSB] != st_q.acc[epa_pkg::EPA_RD_LSB]);
		to_pos = step && above && st_q.dir_known && !st_q.dir_pos && !neg;
		to_neg = step && above && st_q.dir_known && st_q.dir_pos && neg;
	end

	// Ratio handling: zero reads as one, ratio never above one
	always_comb begin
		num_nz = (st_q.num == 12'h000) ? 12'h001 : st_q.num;
		den_nz = (st_q.den == 12'h000) ? 12'h001 : st_q.den;
		eff_den = den_nz;
		eff_num = (num_nz > den_nz) ? den_nz : num_nz;
		frac_sum = {1'b0, st_q.frac} + {2'b00, eff_num} + 14'h0001;
		cf_evt = dfc && (frac_sum >= ({2'b00, eff_den} + 14'h0001));
		fixed_width = (eff_num == 12'h001) && (eff_den == 12'h001);
		if (fixed_width) begin
			width = 25'(epa_pkg::EPA_FIXED_CLKS);
		end else if (st_q.period > LONG_CLKS) begin
			width = WIDE_CLKS;
		end else begin
			width = {1'b0, st_q.period[24:1]};
		end
	end

	// Line-cycle completion and zero-count guard
	always_comb begin
		cyc_target = (st_q.half_cyc == 16'h0000) ? 16'h0001 : st_q.half_cyc;
		lc_done = (st_q.lc_state == epa_pkg::EPA_LC_RUN) && zero_cross
			&& ((st_q.lc_cnt + 16'h0001) >= cyc_target);
	end

	// -----------------------------------------------------------
	// Register bus decode
	// -----------------------------------------------------------
	// Answer is prepared in setup so the access phase never waits
	always_comb begin
		setup = apb_req.psel && !apb_req.penable;
		wr = apb_req.psel && apb_req.penable && st_q.rsp.pready && apb_req.pwrite;
		hit = 1'b1;
		rdata = 32'h0000_0000;
		case (apb_req.paddr)
			epa_pkg::EPA_LC_ENERGY_OFS: rdata = {8'h00, st_q.lc_energy};
			epa_pkg::EPA_HALF_CYC_OFS: rdata = {16'h0000, st_q.half_cyc};
			epa_pkg::EPA_MODE_OFS: rdata = {16'h0000, st_q.mode};
			epa_pkg::EPA_NUM_OFS: rdata = {20'h00000, st_q.num};
			epa_pkg::EPA_DEN_OFS: rdata = {20'h00000, st_q.den};
			epa_pkg::EPA_IRQ_EN_OFS: rdata = {24'h000000, st_q.irq_en};
			epa_pkg::EPA_STATUS_OFS: rdata = {24'h000000, st_q.status};
			epa_pkg::EPA_ENERGY_OFS: rdata = {8'h00, st_q.acc[48:25]};
			default: hit = 1'b0;
		endcase
		st_set = 8'h00;
		st_set[epa_pkg::EPA_ST_CYC_END_BIT] = lc_done;
		st_set[epa_pkg::EPA_ST_TO_POS_BIT] = to_pos;
		st_set[epa_pkg::EPA_ST_TO_NEG_BIT] = to_neg;
	end

	// -----------------------------------------------------------
	// Next state
	// -----------------------------------------------------------
	always_comb begin
		st_d = st_q;
		st_d.tick = st_q.tick + 2'b01;
		// Bus answer: ready only in access phase, error on unmapped
		st_d.rsp.pready = setup;
		if (setup) begin
			st_d.rsp.prdata = rdata;
			st_d.rsp.pslverr = !hit;
		end
		if (wr) begin
			case (apb_req.paddr)
				epa_pkg::EPA_HALF_CYC_OFS: st_d.half_cyc = apb_req.pwdata[15:0];
				epa_pkg::EPA_MODE_OFS: st_d.mode = apb_req.pwdata[15:0];
				epa_pkg::EPA_NUM_OFS: st_d.num = apb_req.pwdata[11:0];
				epa_pkg::EPA_DEN_OFS: st_d.den = apb_req.pwdata[11:0];
				epa_pkg::EPA_IRQ_EN_OFS: st_d.irq_en = apb_req.pwdata[7:0];
				epa_pkg::EPA_STATUS_OFS: st_d.status = st_q.status & ~apb_req.pwdata[7:0];
				default: st_d.status = st_q.status;
			endcase
		end
		// Hardware set wins over a same-cycle write-one clear
		st_d.status = (st_d.status | st_set) & epa_pkg::EPA_STATUS_MASK;
		// Main accumulator
		if (contrib) begin
			st_d.acc = acc_sum;
		end
		if (step && above) begin
			st_d.dir_known = 1'b1;
			st_d.dir_pos = !neg;
		end
		// Pulse-rate divider
		if (cf_evt) begin
			st_d.frac = 13'(frac_sum - ({2'b00, eff_den} + 14'h0001));
		end else if (dfc) begin
			st_d.frac = frac_sum[12:0];
		end
		// Ratio rewrite restarts the divider; an old remainder could exceed a smaller denominator
		if (wr && ((apb_req.paddr == epa_pkg::EPA_NUM_OFS)
			|| (apb_req.paddr == epa_pkg::EPA_DEN_OFS))) begin
			st_d.frac = 13'h0000;
		end
		// Output period measurement, saturating on slow loads
		if (cf_evt) begin
			st_d.period = st_q.period_cnt;
			st_d.period_cnt = 25'd1;
		end else if (st_q.period_cnt != 25'h1FFFFFF) begin
			st_d.period_cnt = st_q.period_cnt + 25'd1;
		end
		// Pulse width; a new event restarts the width
		if (cf_evt) begin
			st_d.width_cnt = width;
		end else if (st_q.width_cnt != 25'd0) begin
			st_d.width_cnt = st_q.width_cnt - 25'd1;
		end
		st_d.cf = (st_d.width_cnt != 25'd0);
		// Line-cycle sequencer
		case (st_q.lc_state)
			epa_pkg::EPA_LC_IDLE: begin
				if (st_q.mode[epa_pkg::EPA_MODE_CYC_BIT]) begin
					st_d.lc_state = epa_pkg::EPA_LC_WAIT;
				end
			end
			epa_pkg::EPA_LC_WAIT: begin
				if (!st_q.mode[epa_pkg::EPA_MODE_CYC_BIT]) begin
					st_d.lc_state = epa_pkg::EPA_LC_IDLE;
				end else if (zero_cross) begin
					st_d.lc_state = epa_pkg::EPA_LC_RUN;
					st_d.lc_acc = '0;
					st_d.lc_cnt = 16'h0000;
				end
			end
			epa_pkg::EPA_LC_RUN: begin
				if (contrib) begin
					st_d.lc_acc = st_q.lc_acc + {{25{active_power[23]}}, active_power};
				end
				if (lc_done) begin
					st_d.lc_energy = st_q.lc_acc[48:25];
					st_d.lc_acc = '0;
					st_d.lc_cnt = 16'h0000;
					// Crossing that ends a run starts the next one while the mode bit is set, else returns to idle
					st_d.lc_state = st_q.mode[epa_pkg::EPA_MODE_CYC_BIT]
						? epa_pkg::EPA_LC_RUN : epa_pkg::EPA_LC_IDLE;
				end else if (!st_q.mode[epa_pkg::EPA_MODE_CYC_BIT]) begin
					st_d.lc_state = epa_pkg::EPA_LC_IDLE;
				end else if (zero_cross) begin
					st_d.lc_cnt = st_q.lc_cnt + 16'h0001;
				end
			end
			default: st_d.lc_state = epa_pkg::EPA_LC_IDLE;
		endcase
		st_d.irq = |(st_d.status & st_d.irq_en);
	end

	// -----------------------------------------------------------
	// State register
	// -----------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st_q <= '0;
			st_q.mode <= epa_pkg::EPA_MODE_RST;
			st_q.num <= epa_pkg::EPA_RATIO_RST;
			st_q.den <= epa_pkg::EPA_RATIO_RST;
			st_q.half_cyc <= epa_pkg::EPA_HALF_CYC_RST;
			st_q.irq_en <= epa_pkg::EPA_IRQ_EN_RST;
			st_q.lc_state <= epa_pkg::EPA_LC_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	// Open-drain pin: drive low only while an enabled flag is set
	assign apb_rsp = st_q.rsp;
	assign calibration_pulse_out = st_q.cf;
	assign irq_n_o = 1'b0;
	assign irq_n_oe = st_q.irq;

	// -----------------------------------------------------------
	// Checks
	// -----------------------------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	sequence s_fixed_evt;
		cf_evt && fixed_width;
	endsequence

	sequence s_fixed_load;
		st_q.cf && (st_q.width_cnt == 25'(epa_pkg::EPA_FIXED_CLKS));
	endsequence

	chk_dfc_lsb_step: assert property (dfc |=> st_q.acc[48:25] != $past(st_q.acc[48:25]))
		else $error("converter pulse without readable energy step");
	chk_frac_below_den: assert property (st_q.frac <= {1'b0, eff_den})
		else $error("divider remainder exceeds denominator");
	chk_zero_as_one: assert property ((st_q.num == 12'h000) |-> eff_num == 12'h001)
		else $error("zero numerator not treated as one");
	chk_ratio_clamp: assert property (eff_num <= eff_den)
		else $error("scale ratio above one");
	chk_fixed_width: assert property (s_fixed_evt |=> s_fixed_load)
		else $error("fixed pulse width not loaded");
	chk_width_count: assert property ((st_q.width_cnt != 25'd0 && !cf_evt)
		|=> st_q.width_cnt == $past(st_q.width_cnt) - 25'd1)
		else $error("pulse width counter did not step down");
	chk_width_end: assert property ((st_q.width_cnt == 25'd1 && !cf_evt) |=> !st_q.cf)
		else $error("pulse output outlived its width");
	chk_cycle_end_flag: assert property (lc_done |=> st_q.status[epa_pkg::EPA_ST_CYC_END_BIT])
		else $error("cycle end flag not set");
	chk_restart_run: assert property ((lc_done && st_q.mode[epa_pkg::EPA_MODE_CYC_BIT])
		|=> st_q.lc_state == epa_pkg::EPA_LC_RUN && st_q.lc_cnt == 16'h0000)
		else $error("line-cycle run did not restart");
	chk_pos_only_hold: assert property ((step && neg && st_q.mode[epa_pkg::EPA_MODE_POS_BIT])
		|=> $stable(st_q.acc))
		else $error("negative power accumulated in positive-only mode");
	chk_noload_hold: assert property ((step && !above) |=> $stable(st_q.acc))
		else $error("energy crept below no-load threshold");
	chk_irq_level: assert property ((|(st_q.status & st_q.irq_en)) == irq_n_oe)
		else $error("interrupt pin disagrees with enabled flags");
endmodule : epa_energy_pulse
`default_nettype wire

// file: epa_cal_counter.sv
// Behavioural calibration counter that watches the pulse output.
// Assumes the pulse output is synchronous to ref_clk and active high.
`timescale 1ns/1ns
`default_nettype none
module epa_cal_counter (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic calibration_pulse_out,
	output var logic [31:0] pulse_count,
	output var logic [31:0] last_width
);
	logic [31:0] run_q;
	logic prev_q;

	// ---------------------------------------------
	// Edge counter and width gauge
	// ---------------------------------------------
	// Width is reported at the falling edge, so a pulse still high never counts
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			run_q <= 32'h0;
			prev_q <= 1'b0;
			pulse_count <= 32'h0;
			last_width <= 32'h0;
		end else begin
			prev_q <= calibration_pulse_out;
			run_q <= calibration_pulse_out ? run_q + 32'h1 : 32'h0;
			if (calibration_pulse_out && !prev_q) begin
				pulse_count <= pulse_count + 32'h1;
			end
			if (!calibration_pulse_out && prev_q) begin
				last_width <= run_q;
			end
		end
	end
endmodule : epa_cal_counter
`default_nettype wire

// file: epa_energy_pulse_tb.sv
// Self-checking bench for the energy pulse block over APB.
// Assumes 125 MHz ref_clk and shortened long-period parameters.
`timescale 1ns/1ns
`default_nettype none
module epa_energy_pulse_tb;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	epa_pkg::epa_apb_req_t req = '0;
	epa_pkg::epa_apb_rsp_t rsp;
	logic signed [23:0] power = 24'h000000;
	logic zc = 1'b0;
	logic zc_on = 1'b0;
	logic cf, irq_o, irq_oe, err;
	logic [31:0] cnt, wid, rd;
	logic [23:0] e0;
	logic [31:0] c0;
	int mismatches = 0, n_compared = 0, cyc = 0, zc_cnt = 0, d;
	logic [11:0] t_num [5] = '{12'h001, 12'h001, 12'h001, 12'h007, 12'h000};
	logic [11:0] t_den [5] = '{12'h001, 12'h003, 12'h007, 12'h001, 12'h000};
	logic [23:0] t_pow [5] = '{24'h080000, 24'h100000, 24'h100000, 24'h080000, 24'h080000};
	int t_div [5] = '{1, 2, 4, 1, 1};
	logic [31:0] t_wid [5] = '{32'h40, 32'h80, 32'hC8, 32'h40, 32'h40};

	// ---------------------------------------------
	// Clock, design, partner
	// ---------------------------------------------
	always #4 ref_clk = ~ref_clk;

	epa_energy_pulse #(.LONG_CLKS(25'h0000190), .WIDE_CLKS(25'h00000C8)) dut_u (
		.ref_clk(ref_clk), .rst(rst), .apb_req(req), .apb_rsp(rsp),
		.active_power(power), .zero_cross(zc), .calibration_pulse_out(cf),
		.irq_n_o(irq_o), .irq_n_oe(irq_oe));

	epa_cal_counter cal_u (.ref_clk(ref_clk), .rst(rst), .calibration_pulse_out(cf),
		.pulse_count(cnt), .last_width(wid));

	// Crossing source every 200 clocks, plus the hang guard
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		zc_cnt <= (zc_cnt == 199) ? 0 : zc_cnt + 1;
		zc <= zc_on && (zc_cnt == 0);
		if (cyc == 70000) begin
			mismatches = mismatches + 1;
			test_done();
		end
	end

	// ---------------------------------------------
	// Tasks
	// ---------------------------------------------
	task automatic test_done();
		$display("Compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : test_done

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	// One APB transfer; answer taken at the rising edge where pready is high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dat);
		@(posedge ref_clk);
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= wr;
		req.paddr <= a;
		req.pwdata <= dat;
		@(posedge ref_clk);
		req.penable <= 1'b1;
		// Only the bench timeout ends a wait that never sees pready
		@(posedge ref_clk);
		while (rsp.pready !== 1'b1) begin
			@(posedge ref_clk);
		end
		rd = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask : apb

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rd, exp);
	endtask : rchk

	// Polls status until the cycle-end flag shows, within a bound
	task automatic wait_flag();
		int n;
		n = 0;
		rd = 32'h0;
		while (rd[2] !== 1'b1 && n < 400) begin
			apb(1'b0, epa_pkg::EPA_STATUS_OFS, 32'h0);
			n++;
		end
		check(32'(rd[2]), 32'h1);
	endtask : wait_flag

	// ---------------------------------------------
	// Main sequence
	// ---------------------------------------------
	initial begin
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		rchk(epa_pkg::EPA_MODE_OFS, 32'h0);
		rchk(epa_pkg::EPA_NUM_OFS, 32'h0);
		rchk(epa_pkg::EPA_DEN_OFS, 32'h0);
		rchk(epa_pkg::EPA_HALF_CYC_OFS, 32'h0000FFFF);
		rchk(epa_pkg::EPA_STATUS_OFS, 32'h0);
		apb(1'b1, epa_pkg::EPA_NUM_OFS, 32'hFFFFFFFF);
		rchk(epa_pkg::EPA_NUM_OFS, 32'h00000FFF);
		apb(1'b1, epa_pkg::EPA_ENERGY_OFS, 32'h00000123);
		rchk(epa_pkg::EPA_ENERGY_OFS, 32'h0);
		apb(1'b0, 8'h3C, 32'h0);
		check(32'(err), 32'h1);
		check(32'(irq_oe), 32'h0);
		// Ratio table: count against energy steps, then pulse width
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, epa_pkg::EPA_NUM_OFS, {20'h0, t_num[i]});
			apb(1'b1, epa_pkg::EPA_DEN_OFS, {20'h0, t_den[i]});
			power <= t_pow[i];
			repeat (2048) @(posedge ref_clk);
			apb(1'b0, epa_pkg::EPA_ENERGY_OFS, 32'h0);
			e0 = rd[23:0];
			c0 = cnt;
			repeat (4096) @(posedge ref_clk);
			apb(1'b0, epa_pkg::EPA_ENERGY_OFS, 32'h0);
			d = int'(cnt - c0) * t_div[i] - int'(rd[23:0] - e0);
			check(32'(d <= 2 * t_div[i] && d >= -2 * t_div[i]), 32'h1);
			check(wid, t_wid[i]);
		end
		// Positive-only with direction flags and masking
		apb(1'b1, epa_pkg::EPA_STATUS_OFS, 32'h34);
		apb(1'b1, epa_pkg::EPA_IRQ_EN_OFS, 32'h20);
		apb(1'b1, epa_pkg::EPA_MODE_OFS, 32'h8000);
		power <= 24'hF00000;
		repeat (200) @(posedge ref_clk);
		rchk(epa_pkg::EPA_STATUS_OFS, 32'h20);
		check(32'(irq_oe), 32'h1);
		check(32'(irq_o), 32'h0);
		apb(1'b0, epa_pkg::EPA_ENERGY_OFS, 32'h0);
		e0 = rd[23:0];
		c0 = cnt;
		repeat (2000) @(posedge ref_clk);
		rchk(epa_pkg::EPA_ENERGY_OFS, {8'h0, e0});
		check(cnt, c0);
		apb(1'b1, epa_pkg::EPA_STATUS_OFS, 32'h20);
		repeat (2) @(posedge ref_clk);
		check(32'(irq_oe), 32'h0);
		power <= 24'h100000;
		repeat (200) @(posedge ref_clk);
		rchk(epa_pkg::EPA_STATUS_OFS, 32'h10);
		check(32'(irq_oe), 32'h0);
		// Signed accumulation, then a creep-level sample
		apb(1'b1, epa_pkg::EPA_MODE_OFS, 32'h0);
		power <= 24'hF00000;
		apb(1'b0, epa_pkg::EPA_ENERGY_OFS, 32'h0);
		e0 = rd[23:0];
		repeat (1000) @(posedge ref_clk);
		apb(1'b0, epa_pkg::EPA_ENERGY_OFS, 32'h0);
		d = int'($signed(rd[23:0] - e0));
		check(32'(d >= -9 && d <= -7), 32'h1);
		apb(1'b1, epa_pkg::EPA_STATUS_OFS, 32'h34);
		power <= 24'h000008;
		repeat (200) @(posedge ref_clk);
		rchk(epa_pkg::EPA_STATUS_OFS, 32'h0);
		// Line-cycle runs over three half cycles, repeated
		apb(1'b1, epa_pkg::EPA_IRQ_EN_OFS, 32'h04);
		apb(1'b1, epa_pkg::EPA_HALF_CYC_OFS, 32'h3);
		rchk(epa_pkg::EPA_HALF_CYC_OFS, 32'h3);
		power <= 24'h400000;
		zc_on <= 1'b1;
		apb(1'b1, epa_pkg::EPA_MODE_OFS, 32'h80);
		wait_flag();
		rchk(epa_pkg::EPA_LC_ENERGY_OFS, 32'h12);
		check(32'(irq_oe), 32'h1);
		apb(1'b1, epa_pkg::EPA_STATUS_OFS, 32'h04);
		wait_flag();
		rchk(epa_pkg::EPA_LC_ENERGY_OFS, 32'h12);
		// Mode bit cleared: the run in flight must never complete
		apb(1'b1, epa_pkg::EPA_MODE_OFS, 32'h0);
		apb(1'b1, epa_pkg::EPA_STATUS_OFS, 32'h04);
		repeat (800) @(posedge ref_clk);
		apb(1'b0, epa_pkg::EPA_STATUS_OFS, 32'h0);
		check(32'(rd[2]), 32'h0);
		zc_on <= 1'b0;
		test_done();
	end
endmodule : epa_energy_pulse_tb
`default_nettype wire
